/* external_pin_interrupts.sv */
// External interrupt logic for three request pins, with APB registers.
// Assumes the core supplies the global enable, clock-run and sleep levels
// on ref_clk, and acknowledges a taken vector with a one-cycle pulse.
`timescale 1ns/1ps

module external_pin_interrupts #(
  parameter int StartupCycles = ext_irq_pkg::STARTUP_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // APB slave
  input wire ext_irq_pkg::apb_req_s apbReq,
  output ext_irq_pkg::apb_rsp_s apbRsp,
  // Pins and port drivers
  input wire logic [2:0] padIn,
  input wire logic [2:0] portOut,
  input wire logic [2:0] portDir,
  // Core side
  input wire logic globalIntEn,
  input wire logic ioClkRun,
  input wire logic sleepPowerDown,
  input wire logic wdtTick,
  input wire logic irqAck,
  input wire logic [1:0] irqAckId,
  // Requests to the core
  output logic irqValid,
  output logic [1:0] irqVecId,
  output logic wakeUp
);
  import ext_irq_pkg::*;

  // Elaboration check on the start-up count
  if (StartupCycles < 1 || StartupCycles >= (1 << CNT_W)) begin : gChk
    $error("StartupCycles out of range");
  end

  // Edge or change event for a given sense mode
  function automatic logic edgeHit(sense_e m, logic prev, logic cur);
    case (m)
      MODE_ANY: edgeHit = prev ^ cur;
      MODE_FALL: edgeHit = prev & ~cur;
      MODE_RISE: edgeHit = ~prev & cur;
      default: edgeHit = 1'b0;
    endcase
  endfunction

  // Sense mode of pin a or b
  function automatic sense_e modeOf(logic [7:0] s, int pin);
    modeOf = sense_e'(pin == PIN_A ? s[SENSE_A_LO +: 2] : s[SENSE_B_LO +: 2]);
  endfunction

  // Address decode, used for both write enable and error
  function automatic logic isMapped(logic [ADDR_W-1:0] a);
    isMapped = (a == OFF_SENSE) || (a == OFF_CSR) || (a == OFF_EN) || (a == OFF_FLAGS);
  endfunction

  // Map a pin-indexed triple onto its register bit positions
  function automatic logic [7:0] toReg(logic [2:0] v);
    toReg = 8'h00;
    toReg[FLAG_A] = v[PIN_A];
    toReg[FLAG_B] = v[PIN_B];
    toReg[FLAG_C] = v[PIN_C];
  endfunction

  logic rstS1_q;
  logic rstn_q;
  state_s st_q;
  state_s st_d;
  logic [2:0] lvl;
  logic [2:0] evt;
  logic [2:0] lowLvl;
  logic [2:0] req;
  logic [2:0] clr;
  logic [7:0] wdat;
  logic access;
  logic done;
  logic wrOk;
  logic polC;
  logic tickEdge;
  logic lowWake;
  logic awake;

  // Reset release through two flops; asserts at once, releases on the clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstS1_q <= 1'b0;
      rstn_q <= 1'b0;
    end else begin
      rstS1_q <= 1'b1;
      rstn_q <= rstS1_q;
    end
  end

  // Next-state logic
  always_comb begin
    st_d = st_q;
    lvl = (portDir & portOut) | (~portDir & padIn);
    evt = 3'h0;
    lowLvl = 3'h0;
    req = 3'h0;
    clr = 3'h0;
    wdat = apbReq.pwdata[7:0];
    access = apbReq.psel & apbReq.penable;
    done = access & st_q.rsp.pready;
    wrOk = done & apbReq.pwrite & isMapped(apbReq.paddr);
    awake = (st_q.wake == WK_RUN);

    // Pin sampling; first stage feeds only the second
    st_d.pinS1 = lvl;
    st_d.pinS2 = st_q.pinS1;
    st_d.tickS1 = wdtTick;
    st_d.tickS2 = st_q.tickS1;
    st_d.tickPrev = st_q.tickS2;
    tickEdge = st_q.tickS2 & ~st_q.tickPrev;

    // Pins a, b: edge history frozen while the I/O clock is stopped
    for (int i = PIN_A; i <= PIN_B; i++) begin
      if (ioClkRun) begin
        st_d.pinPrev[i] = st_q.pinS2[i];
      end
      evt[i] = ioClkRun & edgeHit(modeOf(st_q.sense, i), st_q.pinPrev[i], st_q.pinS2[i]);
      lowLvl[i] = (modeOf(st_q.sense, i) == MODE_LOW) & ~st_q.pinS2[i];
    end

    // Pin c: edge of the polarised level, so a polarity change can fire
    // Software should mask pin c around an edge-select change for that reason
    polC = st_q.senseC ? st_q.pinS2[PIN_C] : ~st_q.pinS2[PIN_C];
    st_d.pinPrev[PIN_C] = polC;
    evt[PIN_C] = polC & ~st_q.pinPrev[PIN_C];

    // Flag clears: written one or vector taken
    if (wrOk && apbReq.paddr == OFF_FLAGS) begin
      clr[PIN_A] = wdat[FLAG_A];
      clr[PIN_B] = wdat[FLAG_B];
      clr[PIN_C] = wdat[FLAG_C];
    end
    if (irqAck) begin
      case (irqAckId)
        VEC_A: clr[PIN_A] = 1'b1;
        VEC_B: clr[PIN_B] = 1'b1;
        VEC_C: clr[PIN_C] = 1'b1;
        default: clr = clr;
      endcase
    end
    // A new event in the clearing cycle keeps the flag set
    // Set wins, so an edge landing on a software clear is never lost
    st_d.flags = (st_q.flags & ~clr) | evt;
    for (int i = PIN_A; i <= PIN_B; i++) begin
      if (modeOf(st_q.sense, i) == MODE_LOW) begin
        st_d.flags[i] = 1'b0;
      end
    end

    // Register writes
    if (wrOk) begin
      case (apbReq.paddr)
        OFF_SENSE: st_d.sense = wdat;
        OFF_CSR: st_d.senseC = wdat[SENSE_C_EDGE];
        OFF_EN: begin
          st_d.en[PIN_A] = wdat[EN_A];
          st_d.en[PIN_B] = wdat[EN_B];
          st_d.en[PIN_C] = wdat[EN_C];
        end
        default: st_d.sense = st_q.sense;
      endcase
    end

    // APB answer: one wait state, data captured with pready
    // Unmapped places answer with an error and read as zero
    st_d.rsp.pready = access & ~st_q.rsp.pready;
    st_d.rsp.pslverr = access & ~st_q.rsp.pready & ~isMapped(apbReq.paddr);
    st_d.rsp.prdata = 32'h0000_0000;
    if (access && !st_q.rsp.pready && !apbReq.pwrite) begin
      case (apbReq.paddr)
        OFF_SENSE: st_d.rsp.prdata[7:0] = st_q.sense;
        OFF_CSR: st_d.rsp.prdata[SENSE_C_EDGE] = st_q.senseC;
        OFF_EN: st_d.rsp.prdata[7:0] = toReg(st_q.en);
        OFF_FLAGS: st_d.rsp.prdata[7:0] = toReg(st_q.flags);
        default: st_d.rsp.prdata = 32'h0000_0000;
      endcase
    end

    // Requests; level is held off until the wake sequence completes
    // Flags of a, b hold edges only; level requests come straight from the pin
    for (int i = PIN_A; i <= PIN_B; i++) begin
      req[i] = st_q.en[i] & globalIntEn &
               ((lowLvl[i] & awake) | st_q.flags[i]);
    end
    req[PIN_C] = st_q.en[PIN_C] & globalIntEn & st_q.flags[PIN_C];

    // Fixed priority, a first; each pin its own vector
    st_d.irqValid = |req;
    if (req[PIN_A]) begin
      st_d.irqVecId = VEC_A;
    end else if (req[PIN_B]) begin
      st_d.irqVecId = VEC_B;
    end else if (req[PIN_C]) begin
      st_d.irqVecId = VEC_C;
    end else begin
      st_d.irqVecId = VEC_NONE;
    end

    // Power-down wake sequencer
    lowWake = |(lowLvl[PIN_B:PIN_A] & st_q.en[PIN_B:PIN_A]);
    case (st_q.wake)
      WK_RUN: begin
        st_d.wakeUp = 1'b0;
        if (sleepPowerDown) begin
          st_d.wake = WK_SLEEP;
        end
      end
      WK_SLEEP: begin
        if (!sleepPowerDown) begin
          st_d.wake = WK_RUN;
        end else if (evt[PIN_C] && st_q.en[PIN_C]) begin
          st_d.wake = WK_START;
          st_d.wakeUp = 1'b1;
          st_d.cnt = CNT_W'(StartupCycles);
        end else if (tickEdge && lowWake) begin
          st_d.wake = WK_SEEN;
        end
      end
      WK_SEEN: begin
        if (!sleepPowerDown) begin
          st_d.wake = WK_RUN;
        end else if (tickEdge) begin
          // A single low sample is treated as noise
          if (lowWake) begin
            st_d.wake = WK_START;
            st_d.wakeUp = 1'b1;
            st_d.cnt = CNT_W'(StartupCycles);
          end else begin
            st_d.wake = WK_SLEEP;
          end
        end
      end
      WK_START: begin
        // Start-up length counts down from the parameter
        // Wake completes regardless of the level; the request then follows it
        if (st_q.cnt <= CNT_W'(1)) begin
          st_d.wake = WK_RUN;
          st_d.wakeUp = 1'b0;
          st_d.cnt = '0;
        end else begin
          st_d.cnt = st_q.cnt - CNT_W'(1);
        end
      end
      default: begin
        st_d.wake = WK_RUN;
        st_d.wakeUp = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn_q) begin
    if (!rstn_q) begin
      // Sync stages start at the pull-up level and a, b history at high,
      // so no false edge follows reset; pin c history is its polarised idle
      st_q <= '{
        pinS1: 3'h7, pinS2: 3'h7, pinPrev: 3'h3,
        tickS1: 1'b0, tickS2: 1'b0, tickPrev: 1'b0,
        sense: RST_SENSE, senseC: RST_SENSE_C,
        en: RST_EN, flags: RST_FLAGS,
        rsp: '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0},
        wake: WK_RUN, cnt: '0, wakeUp: 1'b0,
        irqValid: 1'b0, irqVecId: VEC_NONE
      };
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign apbRsp = st_q.rsp;
  assign irqValid = st_q.irqValid;
  assign irqVecId = st_q.irqVecId;
  assign wakeUp = st_q.wakeUp;

endmodule // external_pin_interrupts

/* ext_irq_pkg.sv */
// Constants, encodings and carrier types for the external pin interrupt block.
// Assumes a 100 MHz register clock and an APB master with 32-bit data.
package ext_irq_pkg;

  // Bus geometry and register byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_SENSE = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CSR = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_EN = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h00C;

  // Field positions inside the 8-bit registers
  localparam int SENSE_A_LO = 0;
  localparam int SENSE_B_LO = 2;
  localparam int SENSE_C_EDGE = 6;
  localparam int EN_B = 7;
  localparam int EN_A = 6;
  localparam int EN_C = 5;
  localparam int FLAG_B = 7;
  localparam int FLAG_A = 6;
  localparam int FLAG_C = 5;

  // Reset values
  localparam logic [7:0] RST_SENSE = 8'h00;
  localparam logic RST_SENSE_C = 1'b0;
  localparam logic [2:0] RST_EN = 3'h0;
  localparam logic [2:0] RST_FLAGS = 3'h0;

  // Pin indices and their vector codes
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam logic [1:0] VEC_NONE = 2'h0;
  localparam logic [1:0] VEC_A = 2'h1;
  localparam logic [1:0] VEC_B = 2'h2;
  localparam logic [1:0] VEC_C = 2'h3;

  // Start-up wait after a wake decision, in ref_clk cycles
  localparam int STARTUP_CYC = 64;
  localparam int CNT_W = 16;

  // Sense modes of pins a and b
  typedef enum logic [1:0] {
    MODE_LOW = 2'h0,
    MODE_ANY = 2'h1,
    MODE_FALL = 2'h2,
    MODE_RISE = 2'h3
  } sense_e;

  // Wake sequencer states, one-hot
  typedef enum logic [3:0] {
    WK_RUN = 4'h1,
    WK_SLEEP = 4'h2,
    WK_SEEN = 4'h4,
    WK_START = 4'h8
  } wake_e;

  // APB request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  // Whole state of the block
  typedef struct packed {
    logic [2:0] pinS1;
    logic [2:0] pinS2;
    logic [2:0] pinPrev;
    logic tickS1;
    logic tickS2;
    logic tickPrev;
    logic [7:0] sense;
    logic senseC;
    logic [2:0] en;
    logic [2:0] flags;
    apb_rsp_s rsp;
    wake_e wake;
    logic [CNT_W-1:0] cnt;
    logic wakeUp;
    logic irqValid;
    logic [1:0] irqVecId;
  } state_s;

endpackage

/* pin_source.sv */
// Behavioural source for the three interrupt pins and the watchdog tick.
// Assumes the bench commands levels on ref_clk; pins idle high on a pull-up.
`timescale 1ns/1ps
module pin_source (
  // Clock and commands
  input wire logic ref_clk,
  input wire logic [2:0] pinLvl,
  input wire logic tickOn,
  // Pin and tick outputs
  output logic [2:0] padIn,
  output logic wdtTick
);
  logic [2:0] divQ = 3'h0;
  // Pull-up level before the first edge
  initial begin
    padIn = 3'h7;
    wdtTick = 1'b0;
  end
  // Levels held whole clocks as commanded, so no pulse is narrower than the minimum
  always @(posedge ref_clk) begin
    padIn <= pinLvl;
    divQ <= divQ + 3'h1;
    wdtTick <= tickOn & divQ[2]; // Tick stands still unless a wake is exercised
  end
endmodule // pin_source

/* external_pin_interrupts_checker.sv */
// Port-level assertions for the external pin interrupt block.
// Assumes it is bound onto external_pin_interrupts and sees its ports only.
`timescale 1ns/1ps
module external_pin_interrupts_checker
  import ext_irq_pkg::*;
#(
  parameter int StartupCycles = STARTUP_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Bus
  input wire ext_irq_pkg::apb_req_s apbReq,
  input wire ext_irq_pkg::apb_rsp_s apbRsp,
  // Core side
  input wire logic globalIntEn,
  input wire logic sleepPowerDown,
  input wire logic irqValid,
  input wire logic [1:0] irqVecId,
  input wire logic wakeUp
);
  logic [7:0] enQ;
  logic [7:0] wakeCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Enable shadow and start-up length counter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enQ <= 8'h00;
      wakeCnt <= 8'h00;
    end else begin
      if (apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite && apbReq.paddr == OFF_EN) begin
        enQ <= apbReq.pwdata[7:0];
      end
      wakeCnt <= wakeUp ? wakeCnt + 8'h01 : 8'h00;
    end
  end
  chk_apb_wait: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready && !$past(apbReq.penable)
    |=> apbRsp.pready) else $error("no ready in second access cycle");
  chk_ready_late: assert property (apbRsp.pready |-> apbReq.penable && $past(apbReq.penable))
    else $error("ready outside second access cycle");
  chk_err_data: assert property (apbRsp.pslverr |-> apbRsp.pready && apbRsp.prdata == 32'h0)
    else $error("bad error answer");
  chk_read_upper: assert property (apbRsp.pready |-> apbRsp.prdata[31:8] == 24'h0
    && (!apbReq.pwrite || apbRsp.prdata == 32'h0)) else $error("read data upper bits set");
  chk_gie_gate: assert property (irqValid |-> $past(globalIntEn))
    else $error("request without global enable");
  chk_vec_enable: assert property (irqValid |-> (irqVecId == VEC_A && $past(enQ[EN_A]))
    || (irqVecId == VEC_B && $past(enQ[EN_B])) || (irqVecId == VEC_C && $past(enQ[EN_C])))
    else $error("vector without its enable");
  chk_wake_len: assert property ($fell(wakeUp) |-> wakeCnt == 8'(StartupCycles))
    else $error("start-up wait wrong length");
  chk_wake_sleep: assert property ($rose(wakeUp) |-> $past(sleepPowerDown))
    else $error("wake outside power-down");
endmodule // external_pin_interrupts_checker

bind external_pin_interrupts external_pin_interrupts_checker #(.StartupCycles(StartupCycles)) u_checker (
  .ref_clk(ref_clk), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp), .globalIntEn(globalIntEn),
  .sleepPowerDown(sleepPowerDown), .irqValid(irqValid), .irqVecId(irqVecId), .wakeUp(wakeUp));

/* testbench.sv */
// Self-checking bench for the external pin interrupt block.
// Assumes the pin source model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module testbench;
  import ext_irq_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  apb_req_s apbReq = '0;
  apb_rsp_s apbRsp;
  logic [2:0] pinLvl = 3'h7, padIn, portOut = 3'h0, portDir = 3'h0;
  logic globalIntEn = 1'b1, ioClkRun = 1'b1, sleepPowerDown = 1'b0, tickOn = 1'b0, irqAck = 1'b0;
  logic [1:0] irqAckId = 2'h0, irqVecId;
  logic wdtTick, irqValid, wakeUp;
  int numErrors = 0, nChecks = 0, cycles = 0;
  // Rows: pin, mode, level before, level after, request expected
  logic [6:0] rows [16] = '{7'h15, 7'h12, 7'h1B, 7'h1C, 7'h0D, 7'h0B, 7'h05, 7'h02,
    7'h35, 7'h3B, 7'h2D, 7'h25, 7'h55, 7'h52, 7'h5B, 7'h5C};

  always #5 ref_clk = ~ref_clk;

  external_pin_interrupts #(.StartupCycles(4)) u_external_pin_interrupts (.ref_clk(ref_clk), .resetn(resetn),
    .apbReq(apbReq), .apbRsp(apbRsp), .padIn(padIn), .portOut(portOut), .portDir(portDir),
    .globalIntEn(globalIntEn), .ioClkRun(ioClkRun), .sleepPowerDown(sleepPowerDown), .wdtTick(wdtTick),
    .irqAck(irqAck), .irqAckId(irqAckId), .irqValid(irqValid), .irqVecId(irqVecId), .wakeUp(wakeUp));
  pin_source u_pin_source (.ref_clk(ref_clk), .pinLvl(pinLvl), .tickOn(tickOn), .padIn(padIn),
    .wdtTick(wdtTick));

  task automatic conclude();
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One APB transfer; ready and data are taken at the rising edge that completes it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic e);
    @(posedge ref_clk);
    apbReq <= '{1'b1, 1'b0, w, a, wd};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    // Values read right after the edge are those the design sampled there
    do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(what, r, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Core takes a vector: one-cycle acknowledge, then two settling cycles
  task automatic ack(input logic [1:0] id);
    @(posedge ref_clk);
    irqAck <= 1'b1;
    irqAckId <= id;
    @(posedge ref_clk);
    irqAck <= 1'b0;
    tick(2);
  endtask

  task automatic pin(input int p, input logic v);
    @(posedge ref_clk);
    pinLvl[p] <= v;
  endtask

  task automatic expIrq(input logic v, input logic [1:0] id);
    @(negedge ref_clk);
    check("irqValid", 32'(irqValid), 32'(v));
    check("irqVecId", 32'(irqVecId), 32'(id));
  endtask

  // Hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      numErrors++;
      conclude();
    end
  end

  initial begin
    logic [6:0] r;
    logic [31:0] d;
    logic e;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    tick(3);
    // Every sense mode of every pin, with the edge-select change done safely
    foreach (rows[i]) begin
      r = rows[i];
      wr(OFF_EN, 32'h0);
      pin(r[6:5], r[2]);
      wr(OFF_SENSE, 32'(r[4:3]) << (2 * r[6:5]));
      wr(OFF_CSR, {25'h0, r[3], 6'h0});
      tick(8);
      wr(OFF_FLAGS, 32'hE0);
      wr(OFF_EN, 32'hE0);
      pin(r[6:5], r[1]);
      tick(8);
      expIrq(r[0], r[0] ? r[6:5] + 2'h1 : VEC_NONE);
      @(posedge ref_clk) pinLvl <= 3'h7;
    end
    // Reset in mid-run, register values and an unmapped place
    @(posedge ref_clk) resetn <= 1'b0;
    tick(3);
    resetn <= 1'b1;
    tick(3);
    for (int a = 0; a < 16; a += 4) rdc("reset", 12'(a), 32'h0);
    apb(1'b0, 12'h010, 32'h0, d, e);
    check("unmapped", {d[30:0], e}, 32'h1);
    wr(OFF_CSR, 32'hFF);
    rdc("csr", OFF_CSR, 32'h40);
    // Flag set, write-one clear, forced clear in level mode
    wr(OFF_SENSE, 32'h01);
    wr(OFF_FLAGS, 32'hE0);
    pin(0, 0);
    tick(8);
    rdc("flag set", OFF_FLAGS, 32'h40);
    wr(OFF_FLAGS, 32'h40);
    rdc("flag clear", OFF_FLAGS, 32'h0);
    pin(0, 1);
    tick(8);
    wr(OFF_SENSE, 32'h00);
    rdc("flag level", OFF_FLAGS, 32'h0);
    // Vector taken clears the request
    wr(OFF_SENSE, 32'h02);
    wr(OFF_FLAGS, 32'hE0);
    wr(OFF_EN, 32'h40);
    pin(0, 0);
    tick(8);
    expIrq(1'b1, VEC_A);
    ack(VEC_A);
    expIrq(1'b0, VEC_NONE);
    // Global enable off holds the request back
    pin(0, 1);
    tick(6);
    @(posedge ref_clk) globalIntEn <= 1'b0;
    pin(0, 0);
    tick(8);
    expIrq(1'b0, VEC_NONE);
    @(posedge ref_clk) globalIntEn <= 1'b1;
    tick(3);
    expIrq(1'b1, VEC_A);
    wr(OFF_EN, 32'h0);
    wr(OFF_FLAGS, 32'hE0);
    // I/O clock stopped: pin a edge lost, pin c edge still seen
    pin(0, 1);
    tick(6);
    @(posedge ref_clk) ioClkRun <= 1'b0;
    pin(0, 0);
    pin(2, 0);
    tick(3);
    pin(2, 1);
    tick(8);
    rdc("no io clock", OFF_FLAGS, 32'h20);
    pin(0, 1);
    tick(6);
    @(posedge ref_clk) ioClkRun <= 1'b1;
    wr(OFF_FLAGS, 32'hE0);
    // Pin driven as output still triggers
    @(posedge ref_clk) portOut <= 3'h1;
    @(posedge ref_clk) portDir <= 3'h1;
    tick(6);
    @(posedge ref_clk) portOut <= 3'h0;
    tick(8);
    rdc("output pin", OFF_FLAGS, 32'h40);
    @(posedge ref_clk) portDir <= 3'h0;
    // Vectors c and b taken; pin c held low must not raise its request again
    wr(OFF_CSR, 32'h0);
    wr(OFF_SENSE, 32'h08);
    wr(OFF_FLAGS, 32'hE0);
    wr(OFF_EN, 32'hA0);
    pin(2, 0);
    tick(8);
    expIrq(1'b1, VEC_C);
    ack(VEC_C);
    expIrq(1'b0, VEC_NONE);
    pin(1, 0);
    tick(8);
    expIrq(1'b1, VEC_B);
    ack(VEC_B);
    expIrq(1'b0, VEC_NONE);
    pin(1, 1);
    pin(2, 1);
    // Power-down wake by level, level gone before start-up ends
    wr(OFF_SENSE, 32'h00);
    wr(OFF_FLAGS, 32'hE0);
    wr(OFF_EN, 32'h40);
    @(posedge ref_clk) sleepPowerDown <= 1'b1;
    pin(0, 0);
    tick(40);
    @(negedge ref_clk);
    check("wake no tick", 32'(wakeUp), 32'h0);
    @(posedge ref_clk) tickOn <= 1'b1;
    while (wakeUp !== 1'b1) @(negedge ref_clk);
    pin(0, 1);
    @(posedge ref_clk) sleepPowerDown <= 1'b0;
    while (wakeUp !== 1'b0) @(negedge ref_clk);
    tick(6);
    expIrq(1'b0, VEC_NONE);
    conclude();
  end
endmodule // testbench
